// File: core/bru_rotate_unit.sv
`timescale 1ns/1ps
`default_nettype none
module bru_rotate_unit
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // decoder
   input wire bru_pkg::bru_op_t op_i,
   // data memory read
   input wire logic [7:0] mem_rdata_i,
   // results
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic [7:0] mem_wdata_o,
   output logic mem_we_o
);
   import bru_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [BRU_DATA_W-1:0] acc;
      logic carry;
      logic [BRU_DATA_W-1:0] wdata;
      logic we;
   } bru_state_t;

   bru_state_t st;
   bru_state_t next_st;
   logic [7:0] rol;
   logic [7:0] ror;
   logic [7:0] rolc;
   logic [7:0] rorc;

   // ****************************************
   // rotate network
   // ****************************************
   // old operand and carry
   assign rol = {mem_rdata_i[6:0], mem_rdata_i[BRU_MSB]};
   assign ror = {mem_rdata_i[BRU_LSB], mem_rdata_i[7:1]};
   assign rolc = {mem_rdata_i[6:0], st.carry};
   assign rorc = {st.carry, mem_rdata_i[7:1]};

   always_comb
   begin
      next_st = st;
      next_st.we = 1'b0;
      unique case (op_i)
         BRU_OP_NONE:
         begin
            next_st.we = 1'b0;
         end
         rotate_left_to_acc_op:
         begin
            next_st.acc = rol;
         end
         rotate_left_through_carry_op:
         begin
            next_st.wdata = rolc;
            next_st.we = 1'b1;
            next_st.carry = mem_rdata_i[BRU_MSB];
         end
         rotate_left_through_carry_to_acc_op:
         begin
            next_st.acc = rolc;
            next_st.carry = mem_rdata_i[BRU_MSB];
         end
         rotate_right_op:
         begin
            next_st.wdata = ror;
            next_st.we = 1'b1;
         end
         rotate_right_to_acc_op:
         begin
            next_st.acc = ror;
         end
         rotate_right_through_carry_op:
         begin
            next_st.wdata = rorc;
            next_st.we = 1'b1;
            next_st.carry = mem_rdata_i[BRU_LSB];
         end
         default:
         begin
            next_st.we = 1'b0;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   // single commit
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         st.acc <= BRU_ACC_RST;
         st.carry <= BRU_CARRY_RST;
         st.wdata <= BRU_ACC_RST;
         st.we <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign acc_o = st.acc;
   assign carry_o = st.carry;
   assign mem_wdata_o = st.wdata;
   assign mem_we_o = st.we;

   // ****************************************
   // checks
   // ****************************************
   a_rol_acc_result: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_left_to_acc_op |=> !mem_we_o
         && acc_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}
         && carry_o == $past(carry_o))
      else $error("left rotate to acc wrong");

   a_rolc_mem_result: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_left_through_carry_op |=> mem_we_o
         && mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(carry_o)}
         && carry_o == $past(mem_rdata_i[7]))
      else $error("left rotate through carry wrong");

   a_rolc_acc_kept: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_left_through_carry_op |=> $stable(acc_o))
      else $error("left rotate through carry touched acc");

   a_rolc_acc_result: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_left_through_carry_to_acc_op |=> !mem_we_o
         && acc_o == {$past(mem_rdata_i[6:0]), $past(carry_o)}
         && carry_o == $past(mem_rdata_i[7]))
      else $error("left rotate carry to acc wrong");

   a_ror_mem_result: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_right_op |=> mem_we_o
         && mem_wdata_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])}
         && $stable(carry_o) && $stable(acc_o))
      else $error("right rotate wrong");

   a_ror_acc_result: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_right_to_acc_op |=> !mem_we_o
         && acc_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])}
         && $stable(carry_o))
      else $error("right rotate to acc wrong");

   a_rorc_mem_result: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_right_through_carry_op |=> mem_we_o
         && mem_wdata_o == {$past(carry_o), $past(mem_rdata_i[7:1])}
         && carry_o == $past(mem_rdata_i[0]))
      else $error("right rotate through carry wrong");

   a_rorc_acc_kept: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == rotate_right_through_carry_op |=> $stable(acc_o))
      else $error("right rotate through carry touched acc");

   a_idle_hold: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      op_i == BRU_OP_NONE |=> !mem_we_o && $stable(carry_o)
         && $stable(acc_o))
      else $error("idle changed state");

   a_carry_cause: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      !(op_i inside {rotate_left_through_carry_op,
         rotate_left_through_carry_to_acc_op,
         rotate_right_through_carry_op})
         |=> $stable(carry_o))
      else $error("carry changed without cause");

   // ****************************************
   // reset and hold checks
   // ****************************************
   a_reset_clears: assert property (
      @(posedge mclk_i)
      sys_rst_i |=> acc_o == BRU_ACC_RST && carry_o == BRU_CARRY_RST
         && !mem_we_o && mem_wdata_o == BRU_ACC_RST)
      else $error("reset values wrong");

   a_acc_cause: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      !(op_i inside {rotate_left_to_acc_op,
         rotate_left_through_carry_to_acc_op,
         rotate_right_to_acc_op})
         |=> $stable(acc_o))
      else $error("acc changed without cause");

   a_we_cause: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      !(op_i inside {rotate_left_through_carry_op,
         rotate_right_op,
         rotate_right_through_carry_op})
         |=> !mem_we_o)
      else $error("memory written without cause");

   a_wdata_hold: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      !(op_i inside {rotate_left_through_carry_op,
         rotate_right_op,
         rotate_right_through_carry_op})
         |=> $stable(mem_wdata_o))
      else $error("write data moved without a write");

   a_bad_code_idle: assert property (
      @(posedge mclk_i) disable iff (sys_rst_i)
      3'(op_i) == 3'h7 |=> !mem_we_o && $stable(carry_o)
         && $stable(acc_o))
      else $error("unused code changed state");
endmodule : bru_rotate_unit
`default_nettype wire

// File: core/bru_pkg.sv
// ****************************************
// rotate unit constants
// ****************************************
package bru_pkg;
   localparam int BRU_DATA_W = 8;
   localparam logic [7:0] BRU_ACC_RST = 8'h00;
   localparam logic BRU_CARRY_RST = 1'b0;
   localparam int BRU_MSB = 7;
   localparam int BRU_LSB = 0;

   typedef enum logic [2:0] {
      BRU_OP_NONE = 3'b000,
      rotate_left_to_acc_op = 3'b001,
      rotate_left_through_carry_op = 3'b010,
      rotate_left_through_carry_to_acc_op = 3'b011,
      rotate_right_op = 3'b100,
      rotate_right_to_acc_op = 3'b101,
      rotate_right_through_carry_op = 3'b110
   } bru_op_t;
endpackage : bru_pkg

// File: verification/bru_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// data memory byte behind the unit
// ****************************************
module bru_mem_model
(
   // clock
   input wire logic clk_i,
   // loader and write back
   input wire logic ld_i,
   input wire logic [7:0] ld_data_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   // operand
   output logic [7:0] rdata_o
);
   always_ff @(posedge clk_i)
      if (we_i)
         rdata_o <= wdata_i;
      else if (ld_i)
         rdata_o <= ld_data_i;
endmodule : bru_mem_model
`default_nettype wire

// File: verification/byte_rotate_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) n_tests++; if ((s) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, s); end
module byte_rotate_unit_tb;
   import bru_pkg::*;
   logic mclk = 0, rst = 1, ld = 1, we, c;
   logic [7:0] ld_d = 0, rd, acc, wd;
   bru_op_t op = BRU_OP_NONE;
   logic [7:0] em = 0, ea = 0, ewd = 0, r;
   logic ec = 0, ew = 0, t;
   int seed = 95409, failures = 0, n_tests = 0;
   always #5 mclk = ~mclk;
   bru_rotate_unit bru_rotate_unit_i (.mclk_i(mclk), .sys_rst_i(rst),
      .op_i(op), .mem_rdata_i(rd), .acc_o(acc), .carry_o(c),
      .mem_wdata_o(wd), .mem_we_o(we));
   bru_mem_model bru_mem_model_i (.clk_i(mclk), .ld_i(ld),
      .ld_data_i(ld_d), .we_i(we), .wdata_i(wd), .rdata_o(rd));
   task end_sim;
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial
   begin
      #20000;
      failures++;
      end_sim;
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 0;
      for (int i = 0; i < 600; i++)
      begin
         @(posedge mclk);
         r = em;
         if (ew)
            em = ewd;
         else if (ld)
            em = ld_d;
         t = ec;
         ew = 0;
         if (i > 0)
            case (op)
               rotate_left_to_acc_op: ea = {r[6:0], r[7]};
               rotate_left_through_carry_op: {ec, ewd, ew} = {r, t, 1'b1};
               rotate_left_through_carry_to_acc_op: {ec, ea} = {r, t};
               rotate_right_op: {ewd, ew} = {r[0], r[7:1], 1'b1};
               rotate_right_to_acc_op: ea = {r[0], r[7:1]};
               rotate_right_through_carry_op: {ewd, ec, ew} = {t, r, 1'b1};
               default: ;
            endcase
         op <= bru_op_t'(3'($random(seed)));
         ld <= 1'($random(seed));
         ld_d <= 8'($random(seed));
         #1;
         `CHK("acc", ea, acc)
         `CHK("carry", ec, c)
         `CHK("we", ew, we)
         if (ew)
         begin
            `CHK("wdata", ewd, wd)
         end
      end
      $display("test random_ops done");
      end_sim;
   end
endmodule : byte_rotate_unit_tb
`default_nettype wire
